// ### rtl/cache_unit_config_chain_access.sv
// configuration and error chain access for the cache / system interface unit
// assumes privileged register accesses arrive as one-cycle strobes on clk_i,
// with retire signalled later by a separate one-cycle pulse
`timescale 1ns/1ps
`include "cfg_chain_regs.svh"
module cache_unit_config_chain_access
  import cfg_chain_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // reset-time serial load
  input  wire logic        built_in_self_test_done_i,
  input  wire logic        rom_bit_i,
  output logic             rom_req_o,
  output logic             once_loaded_o,
  output logic [303:0]     once_cfg_o,
  // privileged register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_idx_i,
  input  wire logic [63:0] reg_wdata_i,
  input  wire logic        wr_retire_i,
  output logic [63:0]      reg_rdata_o,
  // chain contents and error capture
  output logic [35:0]      many_cfg_o,
  input  wire logic        err_load_i,
  input  wire logic [59:0] err_word_i
);

  // ===========================================================================
  // storage
  logic [`ONCE_CHAIN_LEN-1:0] once_q;
  logic [`MANY_CHAIN_LEN-1:0] many_q;
  // all three chains are plain shift registers; none is deep enough for a ram
  // and the used bits of the once and many chains must be visible in parallel to the unit behind them
  logic [`ERR_CHAIN_LEN-1:0]  err_q;
  logic [5:0]                 data_rd_q;
  logic [8:0]                 cnt_q;
  load_state_t                state_q;
  load_state_t                state_d;
  logic                       retire_pend_q;

  chain_stage_if st ();

  chain_stage chain_stage_i (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .st      (st)
  );

  // ===========================================================================
  // register decode
  wire wr_data = reg_wr_i && (reg_idx_i == `IDX_CHAIN_DATA);
  wire wr_trig = reg_wr_i && (reg_idx_i == `IDX_SHIFT_TRIGGER)
                 && reg_wdata_i[`TRIG_BIT];
  wire rd_data = reg_rd_i && (reg_idx_i == `IDX_CHAIN_DATA);
  wire shifting = (state_q == LOAD_SHIFT);
  wire last_bit = shifting && (cnt_q == 9'(`ONCE_CHAIN_LEN - 1));
  // retire only counts once a write has been staged
  wire do_retire = wr_retire_i && retire_pend_q;

  assign st.load  = wr_data;
  assign st.wdata = reg_wdata_i[`DATA_FIELD_MSB:0];
  assign st.shift = do_retire;

  // ===========================================================================
  // reset-time load sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      LOAD_WAIT_BUILT_IN_SELF_TEST: if (built_in_self_test_done_i) state_d = LOAD_SHIFT;
      LOAD_SHIFT:     if (last_bit) state_d = LOAD_DONE;
      LOAD_DONE:      state_d = LOAD_DONE;
      default:        state_d = LOAD_WAIT_BUILT_IN_SELF_TEST;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= LOAD_WAIT_BUILT_IN_SELF_TEST;
      cnt_q   <= 9'h000;
    end else begin
      state_q <= state_d;
      if (shifting) cnt_q <= cnt_q + 9'h001;
    end
  end

  // new bits enter at bit 0 and climb, so the msb sent first ends on top;
  // the surplus head of the image lands above the used field
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      once_q <= '0;
    end else if (shifting) begin
      once_q <= {once_q[`ONCE_CHAIN_LEN-2:0], rom_bit_i};
    end
  end

  // ===========================================================================
  // write-many chain: six bits per retired data write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      many_q        <= '0;
      retire_pend_q <= 1'b0;
    end else begin
      if (do_retire) begin
        many_q <= {st.staged, many_q[`MANY_CHAIN_LEN-1:`CHUNK_BITS]};
      end
      // a new write re-arms even in its own retire cycle
      if (wr_data) retire_pend_q <= 1'b1;
      else if (do_retire) retire_pend_q <= 1'b0;
    end
  end

  // ===========================================================================
  // error chain: capture, then drain six bits per trigger
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_q     <= '0;
      data_rd_q <= 6'h00;
    end else begin
      if (err_load_i) begin
        err_q <= err_word_i;
      end else if (wr_trig) begin
        err_q <= {6'h00, err_q[`ERR_CHAIN_LEN-1:`CHUNK_BITS]};
      end
      if (wr_trig) data_rd_q <= err_q[`CHUNK_BITS-1:0];
    end
  end

  // ===========================================================================
  // outputs, all registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o   <= 64'h0000000000000000;
      rom_req_o     <= 1'b0;
      once_loaded_o <= 1'b0;
      once_cfg_o    <= '0;
      many_cfg_o    <= '0;
    end else begin
      reg_rdata_o   <= rd_data ? {58'h0, data_rd_q} : 64'h0;
      rom_req_o     <= (state_d == LOAD_SHIFT);
      once_loaded_o <= (state_q == LOAD_DONE);
      once_cfg_o    <= once_q[`ONCE_CHAIN_USED-1:0];
      many_cfg_o    <= many_q;
    end
  end

  // ===========================================================================
  // checks
  sequence s_trig_then_read;
    wr_trig ##1 (rd_data && !wr_trig);
  endsequence

  chk_load_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (last_bit |=> state_q == LOAD_DONE && cnt_q == 9'(`ONCE_CHAIN_LEN)))
    else $error("reset chain load did not stop after 367 bits");

  chk_load_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == LOAD_WAIT_BUILT_IN_SELF_TEST && built_in_self_test_done_i) |=> shifting && cnt_q == 9'h000)
    else $error("reset chain load did not start after self-test");

  chk_many_retire: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !do_retire |=> $stable(many_q))
    else $error("write-many chain changed without a retire");

  chk_many_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_retire |=> many_q[35:30] == $past(st.staged))
    else $error("write-many chain did not take six staged bits");

  chk_stage_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_data |=> st.staged == $past(reg_wdata_i[5:0]))
    else $error("staging did not capture low six bits");

  chk_err_drain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_trig && !err_load_i) |=> err_q[59:54] == 6'h00)
    else $error("error chain bits not removed on trigger");

  chk_trig_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_trig_then_read |=> reg_rdata_o[5:0] == $past(err_q[5:0], 2))
    else $error("data read did not return shifted-out bits");

  chk_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rdata_o[63:6] == 58'h0)
    else $error("reserved read bits not zero");

  // ===========================================================================
  // load sequencer checks
  // the load must start on self-test, run its full length and then freeze
  sequence s_wait_idle;
    (state_q == LOAD_WAIT_BUILT_IN_SELF_TEST) && !built_in_self_test_done_i;
  endsequence

  sequence s_shift_step;
    shifting && !last_bit;
  endsequence

  sequence s_load_over;
    state_q == LOAD_DONE;
  endsequence

  chk_built_in_self_test_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wait_idle |=> (state_q == LOAD_WAIT_BUILT_IN_SELF_TEST) && !rom_req_o)
    else $error("reset chain load began before self-test");

  chk_req_window: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rom_req_o == shifting)
    else $error("boot rom request out of step with shifting");

  chk_shift_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_shift_step |=> shifting && (cnt_q == $past(cnt_q) + 9'h001))
    else $error("reset chain load stalled or miscounted");

  chk_msb_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shifting |=> once_q[0] == $past(rom_bit_i))
    else $error("boot rom bit not taken into the chain");

  chk_load_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_load_over |=> (state_q == LOAD_DONE) && $stable(once_q) && $stable(cnt_q))
    else $error("reset chain moved after the load");

  chk_loaded_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_load_over |=> once_loaded_o)
    else $error("load complete flag not raised");

  chk_cnt_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= 9'(`ONCE_CHAIN_LEN))
    else $error("load counter ran past the chain length");

  chk_cfg_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_load_over |=> once_cfg_o == $past(once_q[`ONCE_CHAIN_USED-1:0]))
    else $error("used settings do not follow the chain");

  // ===========================================================================
  // write-many checks
  // a retire without a staged write must leave the chain alone
  sequence s_retire_only;
    do_retire && !wr_data;
  endsequence

  chk_write_arm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_data |=> retire_pend_q)
    else $error("data write did not arm the retire");

  chk_retire_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_retire_only |=> !retire_pend_q)
    else $error("retire left the staged write pending");

  chk_many_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_retire |=> many_q[29:0] == $past(many_q[35:6]))
    else $error("older write-many bits did not move down six");

  chk_many_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    do_retire |=> ##1 (many_cfg_o[35:30] == $past(st.staged, 2)))
    else $error("write-many output missed the retired bits");

  chk_retire_orphan: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_retire_i && !retire_pend_q) |=> $stable(many_q))
    else $error("write-many chain loaded without a data write");

  // ===========================================================================
  // error chain and read checks
  // a trigger with bit 0 clear is not a shift and must not cost any bits
  sequence s_trig_only;
    wr_trig && !err_load_i;
  endsequence

  sequence s_ignored_trig;
    reg_wr_i && (reg_idx_i == `IDX_SHIFT_TRIGGER) && !reg_wdata_i[`TRIG_BIT] && !err_load_i;
  endsequence

  chk_err_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    err_load_i |=> err_q == $past(err_word_i))
    else $error("error chain did not capture the error word");

  chk_err_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!err_load_i && !wr_trig) |=> $stable(err_q))
    else $error("error chain moved without a trigger");

  chk_err_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_trig_only |=> err_q[53:0] == $past(err_q[59:6]))
    else $error("error chain did not shift by six");

  chk_trig_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_trig |=> data_rd_q == $past(err_q[5:0]))
    else $error("trigger did not move six bits to the data window");

  chk_trig_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_ignored_trig |=> $stable(err_q) && $stable(data_rd_q))
    else $error("trigger with bit 0 clear changed the error path");

  chk_rd_nondestruct: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_data && !wr_trig && !err_load_i) |=> $stable(err_q) && $stable(data_rd_q))
    else $error("data read disturbed the error path");

  chk_rd_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_data |=> reg_rdata_o == {58'h0, $past(data_rd_q)})
    else $error("data read returned the wrong bits");

  chk_rd_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_data |=> reg_rdata_o == 64'h0)
    else $error("read data not cleared without a read");

endmodule : cache_unit_config_chain_access

// ### rtl/cfg_chain_regs.svh
// constants for the cache-unit configuration and error chains
// assumes inclusion by bare name from rtl files
`ifndef CFG_CHAIN_REGS_SVH
`define CFG_CHAIN_REGS_SVH

// ===========================================================================
// chain geometry
`define ONCE_CHAIN_LEN      367
`define ONCE_CHAIN_USED     304
`define MANY_CHAIN_LEN      36
`define ERR_CHAIN_LEN       60
`define CHUNK_BITS          6
`define ERR_CHUNKS          10

// ===========================================================================
// register indices and fields
`define IDX_CHAIN_DATA      1'h0
`define IDX_SHIFT_TRIGGER   1'h1
`define DATA_FIELD_MSB      5
`define TRIG_BIT            0

`endif

// ### rtl/cfg_chain_pkg.sv
// types shared by the chain access block
// assumes cfg_chain_regs.svh for the numeric constants
package cfg_chain_pkg;

  // ===========================================================================
  // reset-time load sequencer states
  typedef enum logic [1:0] {
    LOAD_WAIT_BUILT_IN_SELF_TEST = 2'b00,
    LOAD_SHIFT     = 2'b01,
    LOAD_DONE      = 2'b10
  } load_state_t;

endpackage : cfg_chain_pkg

// ### rtl/chain_stage_if.sv
// carrier between the top block and the staging register
// assumes one clock domain
`timescale 1ns/1ps
interface chain_stage_if;
  logic       load;   // capture six bits
  logic [5:0] wdata;  // bits to capture
  logic       shift;  // push staged bits into chain
  logic [5:0] staged; // staged value, registered
  modport owner (output load, output wdata, output shift, input staged);
  modport stage (input load, input wdata, input shift, output staged);
endinterface : chain_stage_if

// ### rtl/chain_stage.sv
// six-bit parallel staging register for writes to the chain data window
// assumes write capture and retire come as separate pulses
`timescale 1ns/1ps
module chain_stage (
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  chain_stage_if.stage  st
);
  logic [5:0] stage_q;

  // ===========================================================================
  // capture on issue; contents hold until the next write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_q <= 6'h00;
    end else if (st.load) begin
      stage_q <= st.wdata;
    end
  end

  // the chain takes the old value on retire, so staging must not move under it
  chk_stage_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.shift && !st.load) |=> $stable(stage_q))
    else $error("staged bits moved during a retire");

  assign st.staged = stage_q;
endmodule : chain_stage

// ### sim/boot_rom_model.sv
// serial boot rom model for the reset-time chain load
// assumes one bit is taken on every rising clk_i edge while req_i is high
`timescale 1ns/1ps
module boot_rom_model (
  input  wire logic clk_i,
  input  wire logic req_i,
  output logic      bit_o,
  output int        taken_o
);
  // ===========================================================================
  // lopsided image, so a chain loaded the wrong way round is caught
  function automatic logic img(input int k);
    return k[0] ^ k[3];
  endfunction : img

  // count of bits handed over; an int starts at zero
  always @(posedge clk_i) if (req_i) taken_o <= taken_o + 1;
  // idle line shows the inverse so a stray sample is caught
  assign bit_o = req_i ? img(taken_o) : ~img(taken_o);
endmodule : boot_rom_model

// ### sim/cache_unit_config_chain_access_test.sv
// self-checking bench for the configuration and error chain block
// assumes the boot rom model beside it and a 5 ns clock
`timescale 1ns/1ps
module cache_unit_config_chain_access_test;
  logic          clk_i, rst_n_i, built_in_self_test_done_i, rom_bit_i, rom_req_o, once_loaded_o;
  logic          reg_wr_i, reg_rd_i, reg_idx_i, wr_retire_i, err_load_i;
  logic [63:0]   reg_wdata_i, reg_rdata_o;
  logic [303:0]  once_cfg_o, exp_once;
  logic [35:0]   many_cfg_o, exp_many;
  logic [59:0]   err_word_i;
  logic [5:0]    d;
  int            failures, n_checks, cycles, taken, i, j;

  cache_unit_config_chain_access cache_unit_config_chain_access_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .built_in_self_test_done_i(built_in_self_test_done_i), .rom_bit_i(rom_bit_i),
    .rom_req_o(rom_req_o), .once_loaded_o(once_loaded_o), .once_cfg_o(once_cfg_o),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i),
    .reg_wdata_i(reg_wdata_i), .wr_retire_i(wr_retire_i), .reg_rdata_o(reg_rdata_o),
    .many_cfg_o(many_cfg_o), .err_load_i(err_load_i), .err_word_i(err_word_i));
  boot_rom_model boot_rom_model_i (.clk_i(clk_i), .req_i(rom_req_o),
    .bit_o(rom_bit_i), .taken_o(taken));

  // ===========================================================================
  // shared tasks
  task automatic chk(input logic [303:0] got, input logic [303:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic idx, input logic [63:0] dat);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_idx_i = idx;
    reg_wdata_i = dat;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  // read data stands one cycle, looked at in that cycle
  task automatic rd(input logic idx, input logic [5:0] e);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_idx_i = idx;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(304'(reg_rdata_o), 304'({58'h0, e}));
  endtask : rd
  // retire pulse, then one cycle for the chain output to follow
  task automatic retire();
    @(negedge clk_i);
    wr_retire_i = 1'b1;
    @(negedge clk_i);
    wr_retire_i = 1'b0;
    @(negedge clk_i);
  endtask : retire
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // ===========================================================================
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      $display("MISMATCH t=%0t timeout", $time);
      give_verdict();
    end
  end

  // ===========================================================================
  // main sequence
  initial begin
    {rst_n_i, built_in_self_test_done_i, reg_wr_i, reg_rd_i, reg_idx_i, wr_retire_i, err_load_i} = '0;
    reg_wdata_i = '0;
    err_word_i = 60'hFED_CBA9_8765_4321;
    // msb first: the bit sent k-th climbs to chain bit 366-k
    for (i = 0; i < 304; i++) begin
      j = 366 - i;
      exp_once[i] = j[0] ^ j[3];
    end
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(304'(many_cfg_o), 304'h0);
    repeat (5) @(negedge clk_i);
    chk(304'(rom_req_o), 304'h0);
    built_in_self_test_done_i = 1'b1;
    for (i = 0; i < 500 && once_loaded_o !== 1'b1; i++) @(negedge clk_i);
    chk(304'(taken), 304'(367));
    chk(once_cfg_o, exp_once);
    // six loads with reserved bits set; nothing moves before retire
    exp_many = '0;
    for (i = 0; i < 6; i++) begin
      d = 6'(i * 11 + 5);
      wr(1'b0, {58'h3FF_FFFF_FFFF_FFFF, d});
      repeat (2) @(negedge clk_i);
      chk(304'(many_cfg_o), 304'(exp_many));
      retire();
      exp_many = {d, exp_many[35:6]};
      chk(304'(many_cfg_o), 304'(exp_many));
    end
    wr(1'b1, 64'h0);
    retire();
    chk(304'(many_cfg_o), 304'(exp_many));
    // error chain: capture, an ignored trigger, then ten drains
    @(negedge clk_i);
    err_load_i = 1'b1;
    @(negedge clk_i);
    err_load_i = 1'b0;
    wr(1'b1, 64'hFFFF_FFFF_FFFF_FFFE);
    for (i = 0; i < 10; i++) begin
      wr(1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
      rd(1'b0, err_word_i[6*i +: 6]);
      rd(1'b0, err_word_i[6*i +: 6]);
    end
    rd(1'b1, 6'h0);
    wr(1'b1, 64'h1);
    rd(1'b0, 6'h0);
    chk(304'(taken), 304'(367));
    give_verdict();
  end
endmodule : cache_unit_config_chain_access_test
